//--- verilog/mrb_bit_bank.sv
`timescale 1ns/1ns
// Summary of operation
// - reset loads every bit's default
// - defaults: none, zero, or one
// - strap pin level captured at reset
// - latch-high bit catches condition assertion
// - latch-high holds until reset or read
// - read reloads latch-high with live value
// - latch-low catches low, holds until read
// - read reloads latch-low with live value
// - max group holds highest state reached
// - max group holds until reset/read
// - read reloads max group with current state
// - self-clear trigger bits reset to zero
// - writing one starts the assigned function
// - bit clears itself when function completes
// - writes to read-only bits ignored
// - override bits writable only while armed
// - write-zero bits accept only zeros
module mrb_bit_bank
    import mrb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic hi_cond,
    input wire logic lo_cond_n,
    input wire logic [2:0] sm_state,
    input wire logic [15:0] fault_set,
    input wire logic strap_addr0_led_pin,
    input wire logic strap_addr1_led_pin,
    input wire logic strap_addr2_led_pin,
    input wire logic strap_addr3_led_pin,
    input wire logic strap_addr4_led_pin,
    output logic irq,
    output logic func_busy,
    output logic [7:0] cfg_out,
    output logic [3:0] test_out,
    output logic [15:0] ovr_out,
    output logic [4:0] strap_addr
);

    // ---------------------------------------------------------------
    // strap pin synchronisers and agreement filter
    // ---------------------------------------------------------------
    logic [STRAP_W-1:0] strap_in;
    logic [STRAP_W-1:0] strap_filt;

    assign strap_in = {strap_addr4_led_pin, strap_addr3_led_pin, strap_addr2_led_pin,
                       strap_addr1_led_pin, strap_addr0_led_pin};

    genvar gi;
    generate
        for (gi = 0; gi < STRAP_W; gi = gi + 1)
        begin : g_strap
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic f_r;
            always_ff @(posedge aclk)
            begin
                s1_r <= strap_in[gi];
                s2_r <= s1_r;
                s3_r <= s2_r;
                if (s2_r == s3_r)
                begin
                    f_r <= s3_r;
                end
            end
            assign strap_filt[gi] = f_r;
        end
    endgenerate

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    mrb_wreq_t wreq_r, wreq_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic sc_r, sc_nxt, arm_r, arm_nxt;
    logic [3:0] test_r, test_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [15:0] ovr_r, ovr_nxt, wz_r, wz_nxt, scratch_r, scratch_nxt;
    logic [4:0] strap_r, strap_nxt;
    mrb_latch_t lat_r, lat_nxt;
    mrb_irq_t ist_r, ist_nxt, evt;
    logic [2:0] mask_r, mask_nxt;
    logic irq_r, irq_nxt;
    logic wr_go, ar_hs, rd_latch, rd_irq, sc_start, sc_busy, sc_done;
    logic [7:0] wa, ra;
    logic [15:0] wmask, wmerge, wctrl;
    logic [31:0] rd_mux;
    logic rd_map, wr_map;

    mrb_sc_engine u_sc (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(sc_start),
        .busy(sc_busy),
        .done(sc_done)
    );

    // ---------------------------------------------------------------
    // decode and read mux
    // ---------------------------------------------------------------
    assign wa = {wreq_r.addr[7:2], 2'b00};
    assign ra = {s_axi_araddr[7:2], 2'b00};
    assign wr_go = aw_full_r && w_full_r && !bvalid_r;
    assign ar_hs = s_axi_arvalid && arready_r;
    assign rd_latch = ar_hs && (ra == ADDR_LATCH);
    assign rd_irq = ar_hs && (ra == ADDR_IRQ_STAT);
    assign wmask = {{8{wreq_r.strb[1]}}, {8{wreq_r.strb[0]}}};
    assign wctrl = {sc_r, arm_r, 2'b00, test_r, cfg_r};

    always_comb
    begin
        wmerge = (wreq_r.data[15:0] & wmask) | (wctrl & ~wmask);
        unique case (wa)
            ADDR_STRAP: wmerge = (wreq_r.data[15:0] & wmask) | ({11'h000, strap_r} & ~wmask);
            ADDR_OVR: wmerge = (wreq_r.data[15:0] & wmask) | (ovr_r & ~wmask);
            ADDR_IRQ_MASK: wmerge = (wreq_r.data[15:0] & wmask) | ({13'h0000, mask_r} & ~wmask);
            ADDR_SCRATCH: wmerge = (wreq_r.data[15:0] & wmask) | (scratch_r & ~wmask);
            default: wmerge = (wreq_r.data[15:0] & wmask) | (wctrl & ~wmask);
        endcase
    end

    always_comb
    begin
        rd_map = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (ra)
            ADDR_CTRL: rd_mux = {16'h0000, wctrl};
            ADDR_STRAP: rd_mux = {27'h0000000, strap_r};
            ADDR_LATCH: rd_mux = {25'h0000000, lat_r.latch_max_group, 2'b00, lat_r.latch_low_bit,
                                  lat_r.latch_high_bit};
            ADDR_OVR: rd_mux = {16'h0000, ovr_r};
            ADDR_WZERO: rd_mux = {16'h0000, wz_r};
            ADDR_IRQ_STAT: rd_mux = {29'h00000000, ist_r};
            ADDR_IRQ_MASK: rd_mux = {29'h00000000, mask_r};
            ADDR_LIVE: rd_mux = {26'h0000000, sm_state, lo_cond_n, hi_cond, sc_r};
            ADDR_SCRATCH: rd_mux = {16'h0000, scratch_r};
            default: rd_map = 1'b0;
        endcase
        wr_map = (wa <= ADDR_SCRATCH);
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        wreq_nxt = wreq_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        test_nxt = test_r;
        cfg_nxt = cfg_r;
        ovr_nxt = ovr_r;
        strap_nxt = strap_r;
        mask_nxt = mask_r;
        scratch_nxt = scratch_r;
        arm_nxt = arm_r;
        if (s_axi_awvalid && awready_r)
        begin
            aw_full_nxt = 1'b1;
            wreq_nxt.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r)
        begin
            w_full_nxt = 1'b1;
            wreq_nxt.data = s_axi_wdata;
            wreq_nxt.strb = s_axi_wstrb;
        end
        if (wr_go)
        begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_map ? RESP_OKAY : RESP_SLVERR;
            arm_nxt = 1'b0;
            unique case (wa)
                ADDR_CTRL:
                begin
                    cfg_nxt = wmerge[7:0];
                    test_nxt = wmerge[11:8];
                    arm_nxt = wreq_r.strb[1] && wreq_r.data[CTRL_ARM_BIT];
                end
                ADDR_STRAP: strap_nxt = wmerge[4:0];
                ADDR_OVR:
                begin
                    if (arm_r)
                    begin
                        ovr_nxt = wmerge;
                    end
                end
                ADDR_IRQ_MASK: mask_nxt = wmerge[2:0];
                ADDR_SCRATCH: scratch_nxt = wmerge;
                default: ovr_nxt = ovr_r;
            endcase
        end
        else if (bvalid_r && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        awready_nxt = !aw_full_nxt;
        wready_nxt = !w_full_nxt;
        if (ar_hs)
        begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_mux;
            rresp_nxt = rd_map ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        arready_nxt = !rvalid_nxt;
    end

    // self-clear trigger, write-zero bits, latches, interrupts
    always_comb
    begin
        sc_start = wr_go && (wa == ADDR_CTRL) && wreq_r.strb[1] && wreq_r.data[CTRL_SC_BIT] && !sc_r;
        sc_nxt = (sc_r && !sc_done) || sc_start;
        wz_nxt = wz_r | fault_set;
        if (wr_go && (wa == ADDR_WZERO))
        begin
            wz_nxt = (wz_r & ~(~wreq_r.data[15:0] & wmask)) | fault_set;
        end
        lat_nxt.latch_high_bit = rd_latch ? hi_cond : (lat_r.latch_high_bit | hi_cond);
        lat_nxt.latch_low_bit = rd_latch ? lo_cond_n : (lat_r.latch_low_bit & lo_cond_n);
        if (rd_latch)
        begin
            lat_nxt.latch_max_group = sm_state;
        end
        else if (sm_state > lat_r.latch_max_group)
        begin
            lat_nxt.latch_max_group = sm_state;
        end
        else
        begin
            lat_nxt.latch_max_group = lat_r.latch_max_group;
        end
        evt.sc_done = sc_done;
        evt.hi_evt = hi_cond && !lat_r.latch_high_bit;
        evt.lo_evt = !lo_cond_n && lat_r.latch_low_bit;
        ist_nxt = (rd_irq ? 3'h0 : ist_r) | evt;
        irq_nxt = |(ist_nxt & mask_nxt);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            wreq_r <= '0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            arready_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            sc_r <= 1'b0;
            arm_r <= 1'b0;
            test_r <= TEST_RST;
            cfg_r <= CFG_RST;
            ovr_r <= OVR_RST;
            wz_r <= WZERO_RST;
            strap_r <= strap_filt;
            lat_r <= {MAX_RST, LATCH_LO_RST, LATCH_HI_RST};
            ist_r <= 3'h0;
            mask_r <= MASK_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            wreq_r <= wreq_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            arready_r <= arready_nxt;
            bvalid_r <= bvalid_nxt;
            rvalid_r <= rvalid_nxt;
            bresp_r <= bresp_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            sc_r <= sc_nxt;
            arm_r <= arm_nxt;
            test_r <= test_nxt;
            cfg_r <= cfg_nxt;
            ovr_r <= ovr_nxt;
            wz_r <= wz_nxt;
            strap_r <= strap_nxt;
            lat_r <= lat_nxt;
            ist_r <= ist_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // scratch word has no default value
    always_ff @(posedge aclk)
    begin
        scratch_r <= scratch_nxt;
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign irq = irq_r;
    assign func_busy = sc_r;
    assign cfg_out = cfg_r;
    assign test_out = test_r;
    assign ovr_out = ovr_r;
    assign strap_addr = strap_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    localparam int A_SC_MAX = SC_CYCLES + 2;

    sequence s_sc_start;
        sc_start;
    endsequence

    sequence s_sc_finish;
        ##[1:A_SC_MAX] !sc_r;
    endsequence

    a_reset_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> (cfg_r == CFG_RST) && (test_r == TEST_RST) && !sc_r && !arm_r && lat_r.latch_low_bit)
        else $error("defaults not loaded at reset");
    a_strap_capture: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> strap_r == $past(strap_filt))
        else $error("strap level not captured");
    a_hi_latch_set: assert property (@(posedge aclk) disable iff (!aresetn)
        hi_cond |=> lat_r.latch_high_bit)
        else $error("latch high missed event");
    a_hi_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        lat_r.latch_high_bit && !rd_latch |=> lat_r.latch_high_bit)
        else $error("latch high dropped without read");
    a_hi_latch_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_latch |=> lat_r.latch_high_bit == $past(hi_cond))
        else $error("latch high not reloaded");
    a_lo_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (!lat_r.latch_low_bit || !lo_cond_n) && !rd_latch |=> !lat_r.latch_low_bit)
        else $error("latch low not held");
    a_lo_latch_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_latch |=> lat_r.latch_low_bit == $past(lo_cond_n))
        else $error("latch low not reloaded");
    a_max_track: assert property (@(posedge aclk) disable iff (!aresetn)
        !rd_latch |=> (lat_r.latch_max_group >= $past(lat_r.latch_max_group))
                      && (lat_r.latch_max_group >= $past(sm_state)))
        else $error("max group lost its maximum");
    a_max_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_latch |=> lat_r.latch_max_group == $past(sm_state))
        else $error("max group not reloaded");
    a_sc_completes: assert property (@(posedge aclk) disable iff (!aresetn)
        s_sc_start |-> s_sc_finish)
        else $error("self-clear bit did not clear");
    a_sc_starts: assert property (@(posedge aclk) disable iff (!aresetn)
        sc_start |=> sc_r && sc_busy)
        else $error("trigger did not start function");
    a_override_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && !arm_r |=> ovr_r == $past(ovr_r) && (!arm_r || $past(wa) == ADDR_CTRL))
        else $error("override bits written while not armed");
    a_wzero_only: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && (fault_set == 16'h0000) |=> (wz_r & ~$past(wz_r)) == 16'h0000)
        else $error("write set a write-zero bit");

endmodule : mrb_bit_bank

//--- inc/mrb_pkg.sv
package mrb_pkg;

    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SC_TIME_NS = 1000;
    localparam int SC_CYCLES = (SC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SC_LAST = 8'(SC_CYCLES - 1);

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STRAP = 8'h04;
    localparam logic [7:0] ADDR_LATCH = 8'h08;
    localparam logic [7:0] ADDR_OVR = 8'h0C;
    localparam logic [7:0] ADDR_WZERO = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_LIVE = 8'h1C;
    localparam logic [7:0] ADDR_SCRATCH = 8'h20;

    // ---------------------------------------------------------------
    // field positions and values after reset
    // ---------------------------------------------------------------
    localparam int CTRL_SC_BIT = 15;
    localparam int CTRL_ARM_BIT = 14;
    localparam logic [3:0] TEST_RST = 4'hA;
    localparam logic [7:0] CFG_RST = 8'h01;
    localparam logic [15:0] OVR_RST = 16'h0000;
    localparam logic [15:0] WZERO_RST = 16'h0000;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [2:0] MAX_RST = 3'h0;
    localparam logic LATCH_HI_RST = 1'b0;
    localparam logic LATCH_LO_RST = 1'b1;
    localparam int LATCH_MAX_LSB = 4;
    localparam int STRAP_W = 5;

    // ---------------------------------------------------------------
    // bus responses
    // ---------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0] latch_max_group;
        logic latch_low_bit;
        logic latch_high_bit;
    } mrb_latch_t;

    typedef struct packed {
        logic lo_evt;
        logic hi_evt;
        logic sc_done;
    } mrb_irq_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } mrb_wreq_t;

endpackage : mrb_pkg

//--- verilog/mrb_sc_engine.sv
`timescale 1ns/1ns
module mrb_sc_engine
    import mrb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    output logic busy,
    output logic done
);

    // ---------------------------------------------------------------
    // triggered function: runs a fixed time, then reports done
    // ---------------------------------------------------------------
    typedef enum logic {SC_IDLE, SC_RUN} mrb_sc_state_t;

    mrb_sc_state_t state_r;
    mrb_sc_state_t state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        unique case (state_r)
            SC_IDLE:
            begin
                if (start)
                begin
                    state_nxt = SC_RUN;
                    cnt_nxt = 8'h00;
                end
            end
            SC_RUN:
            begin
                if (cnt_r == SC_LAST)
                begin
                    state_nxt = SC_IDLE;
                    done_nxt = 1'b1;
                end
                else
                begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= SC_IDLE;
            cnt_r <= 8'h00;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = (state_r == SC_RUN);
    assign done = done_r;

endmodule : mrb_sc_engine

//--- test/mrb_mgmt_model.sv
`timescale 1ns/1ns
// ----------------
// management controller model
// ----------------
module mrb_mgmt_model
    import mrb_pkg::*;
(
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic [31:0] v;
        v = d;
        if (a == ADDR_CTRL) v[11:8] = TEST_RST;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 200) tb_mrb_bit_bank.final_report(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 200) tb_mrb_bit_bank.final_report(1);
    endtask : rd
endmodule : mrb_mgmt_model

//--- test/tb_mrb_bit_bank.sv
`timescale 1ns/1ns
module tb_mrb_bit_bank import mrb_pkg::*;;
    logic aclk, aresetn, hi_cond, lo_cond_n, irq, func_busy;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cfg_out;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, test_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [2:0] sm_state;
    logic [15:0] fault_set, ovr_out;
    logic [4:0] strap_addr;
    logic strap_addr0_led_pin, strap_addr1_led_pin, strap_addr2_led_pin;
    logic strap_addr3_led_pin, strap_addr4_led_pin;
    int errors = 0;
    int checks_done = 0;
    int n;
    localparam logic [31:0] CTRL_DEF = 32'({TEST_RST, CFG_RST});

    mrb_bit_bank dut (.*);
    mrb_mgmt_model m (.*);

    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] lat(input logic [2:0] x, input logic l, input logic h);
        return 32'({x, 2'b00, l, h});
    endfunction : lat

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        m.wr(a, d, rr);
        chk(32'(rr), 32'(e));
    endtask : w

    task automatic r(input logic [7:0] a, input logic [31:0] e);
        m.rd(a, rv, rr);
        chk(rv, e);
    endtask : r

    task automatic final_report(input int extra);
        errors += extra;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ----------------
    // scenarios
    // ----------------
    initial
    begin
        {aresetn, hi_cond, lo_cond_n, sm_state, fault_set} = 22'h080000;
        {strap_addr4_led_pin, strap_addr3_led_pin, strap_addr2_led_pin} = 3'h5;
        {strap_addr1_led_pin, strap_addr0_led_pin} = 2'h1;
        do_reset();
        r(ADDR_CTRL, CTRL_DEF);
        chk(32'(test_out), 32'(TEST_RST));
        r(ADDR_STRAP, 32'h15);
        chk(32'(strap_addr), 32'h15);
        r(ADDR_LATCH, lat(MAX_RST, LATCH_LO_RST, LATCH_HI_RST));
        @(posedge aclk);
        {sm_state, hi_cond, lo_cond_n} <= 5'b01110;
        @(posedge aclk);
        {sm_state, hi_cond, lo_cond_n} <= 5'b10101;
        @(posedge aclk);
        sm_state <= 3'd2;
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h0);
        r(ADDR_LATCH, lat(3'd5, 1'b0, 1'b1));
        r(ADDR_LATCH, lat(3'd2, 1'b1, 1'b0));
        w(ADDR_IRQ_MASK, 32'h2, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        r(ADDR_IRQ_STAT, 32'h6);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        w(ADDR_CTRL, CTRL_DEF | 32'h8000, RESP_OKAY);
        r(ADDR_CTRL, CTRL_DEF | 32'h8000);
        chk(32'(func_busy), 32'h1);
        for (n = 0; n < 150 && func_busy; n++) @(posedge aclk);
        if (n >= 150) final_report(1);
        chk(32'(n > SC_CYCLES - 10 && n <= SC_CYCLES + 2), 32'h1);
        r(ADDR_CTRL, CTRL_DEF);
        r(ADDR_IRQ_STAT, 32'h1);
        w(ADDR_OVR, 32'h1234, RESP_OKAY);
        chk(32'(ovr_out), 32'h0);
        w(ADDR_CTRL, CTRL_DEF | 32'h4000, RESP_OKAY);
        w(ADDR_OVR, 32'h1234, RESP_OKAY);
        chk(32'(ovr_out), 32'h1234);
        w(ADDR_OVR, 32'h5555, RESP_OKAY);
        r(ADDR_OVR, 32'h1234);
        chk(32'(test_out), 32'(TEST_RST));
        @(posedge aclk);
        fault_set <= 16'h00FF;
        @(posedge aclk);
        fault_set <= 16'h0000;
        r(ADDR_WZERO, 32'h00FF);
        w(ADDR_WZERO, 32'hFFF0, RESP_OKAY);
        r(ADDR_WZERO, 32'h00F0);
        w(ADDR_LIVE, 32'hFFFF, RESP_OKAY);
        r(ADDR_LIVE, 32'({3'd2, 1'b1, 1'b0, 1'b0}));
        w(ADDR_LATCH, 32'hFFFF_FFFF, RESP_OKAY);
        r(ADDR_LATCH, lat(3'd2, 1'b1, 1'b0));
        w(ADDR_SCRATCH, 32'h5A5A, RESP_OKAY);
        r(ADDR_SCRATCH, 32'h5A5A);
        m.rd(8'h24, rv, rr);
        chk(32'(rr), 32'(RESP_SLVERR));
        chk(rv, 32'h0);
        w(8'h24, 32'h0, RESP_SLVERR);
        do_reset();
        r(ADDR_OVR, 32'(OVR_RST));
        r(ADDR_IRQ_MASK, 32'(MASK_RST));
        chk(32'(cfg_out), 32'(CFG_RST));
        final_report(0);
    end
endmodule : tb_mrb_bit_bank
